//--- rtl/cmpc_pkg.sv
// What this block does
// - Mux enable, converter off: channel picks negative
// - Otherwise negative input is dedicated pin
// - Power-off bit 7 cuts comparator power
// - Bandgap select feeds reference to positive
// - Result bit synchronized, one-two cycle latency
// - Selected event sets event flag
// - Mode 00 toggle, 10 fall, 11 rise
// - Interrupt needs flag, enable, global enable
// - Flag clears on vector or one-write
// - Capture route drives timer capture input
// - Buffer-off bits disable pin input buffers
// - Upper six disable bits read zero
`default_nettype none
package cmpc_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] CMPC_ADDR_CTRL = 8'h50;
  localparam logic [7:0] CMPC_ADDR_CONVB = 8'h7b;
  localparam logic [7:0] CMPC_ADDR_DIDIS = 8'h7f;
  localparam logic [7:0] CMPC_ADDR_CHSEL = 8'h7c;
  localparam logic [7:0] CMPC_ADDR_CONVA = 8'h7a;
  localparam logic [7:0] CMPC_ADDR_GLOB = 8'h5f;
  localparam logic [7:0] CMPC_ADDR_IMASK = 8'h60;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMPC_B_PWROFF = 7;
  localparam int CMPC_B_BGSEL = 6;
  localparam int CMPC_B_RESULT = 5;
  localparam int CMPC_B_FLAG = 4;
  localparam int CMPC_B_IRQEN = 3;
  localparam int CMPC_B_CAPRT = 2;
  localparam int CMPC_B_MODEHI = 1;
  localparam int CMPC_B_MODELO = 0;
  localparam int CMPC_B_MUXEN = 6;
  localparam int CMPC_B_CONVEN = 7;
  localparam int CMPC_B_GLOBIE = 7;
  localparam int CMPC_B_NEGOFF = 1;
  localparam int CMPC_B_POSOFF = 0;
  localparam logic [7:0] CMPC_CONVB_MASK = 8'h47;
  localparam logic [7:0] CMPC_DIDIS_MASK = 8'h03;
  localparam logic [7:0] CMPC_CTRL_WMASK = 8'hcf;
  localparam logic [7:0] CMPC_CHSEL_MASK = 8'h07;
  localparam logic [7:0] CMPC_RST8 = 8'h00;
  // ----------------------------------------
  // Event modes
  // ----------------------------------------
  localparam logic [1:0] CMPC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] CMPC_MODE_RSVD = 2'h1;
  localparam logic [1:0] CMPC_MODE_FALL = 2'h2;
  localparam logic [1:0] CMPC_MODE_RISE = 2'h3;
  typedef enum logic [1:0] {CMPC_BUS_IDLE = 2'b01, CMPC_BUS_ACK = 2'b10} cmpc_bus_t;
endpackage : cmpc_pkg
`default_nettype wire

//--- rtl/cmpc_sync.sv
`default_nettype none
// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module cmpc_sync (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_ff;
  logic stage2_ff;
  // First stage read only by the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end
  assign syncOut = stage2_ff;
endmodule : cmpc_sync
`default_nettype wire

//--- rtl/cmpc_top.sv
`default_nettype none
module cmpc_top
  import cmpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator core
  input wire logic cmpRaw,
  output logic cmpPowerOff,
  output logic posSelBandgap,
  output logic negSelChannel,
  output logic [2:0] negChannel,
  // Processor interrupt handshake
  input wire logic irqVectorAck,
  output logic irqReq,
  // Timer capture front end
  output logic captureIn,
  output logic captureSelCmp,
  // Pin digital buffers
  output logic negPinBufferOff,
  output logic posPinBufferOff
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic flag_ff;
  logic [7:0] convB_ff;
  logic [7:0] convA_ff;
  logic [7:0] chSel_ff;
  logic [7:0] glob_ff;
  logic [7:0] iMask_ff;
  logic [1:0] dis_ff;
  logic prev_ff;
  logic ackVec_ff;
  logic [31:0] rdat_ff;
  logic ack_ff;
  logic irq_ff;
  logic capIn_ff;
  logic capSel_ff;
  logic negSel_ff;
  logic [2:0] negCh_ff;
  // Bus walk state
  cmpc_bus_t bus_ff;
  cmpc_bus_t nxt_bus;
  logic cmpSync;

  cmpc_sync u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(cmpRaw),
    .syncOut(cmpSync)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire busReq = wb_cyc_i && wb_stb_i && (bus_ff == CMPC_BUS_IDLE);
  // Writes commit at the edge where the master samples ack, while it still holds the request
  wire ackPhase = wb_cyc_i && wb_stb_i && (bus_ff == CMPC_BUS_ACK);
  wire wrEn = ackPhase && wb_we_i && wb_sel_i[0];
  wire hitCtrl = (wb_adr_i == CMPC_ADDR_CTRL);
  wire hitConvB = (wb_adr_i == CMPC_ADDR_CONVB);
  wire hitConvA = (wb_adr_i == CMPC_ADDR_CONVA);
  wire hitChSel = (wb_adr_i == CMPC_ADDR_CHSEL);
  wire hitDis = (wb_adr_i == CMPC_ADDR_DIDIS);
  wire hitGlob = (wb_adr_i == CMPC_ADDR_GLOB);
  wire hitMask = (wb_adr_i == CMPC_ADDR_IMASK);
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wrCtrl = wrEn && hitCtrl;

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // edge pulses
  wire riseEv = cmpSync && !prev_ff;
  wire fallEv = !cmpSync && prev_ff;
  wire [1:0] mode = {ctrl_ff[CMPC_B_MODEHI], ctrl_ff[CMPC_B_MODELO]};
  // mode decode, reserved mode flags nothing
  wire modeTog = (mode == CMPC_MODE_TOGGLE) && (riseEv || fallEv);
  wire modeFall = (mode == CMPC_MODE_FALL) && fallEv;
  wire modeRise = (mode == CMPC_MODE_RISE) && riseEv;
  wire evHit = modeTog || modeFall || modeRise;
  // clear sources; a vector ack only counts once
  wire vecPulse = irqVectorAck && !ackVec_ff;
  wire clrFlag = (wrCtrl && wbyte[CMPC_B_FLAG]) || vecPulse;
  wire nxt_flag = evHit ? 1'b1 : (clrFlag ? 1'b0 : flag_ff);

  // ----------------------------------------
  // Negative input select
  // ----------------------------------------
  // channel routed when mux on, converter off
  wire nxt_negSel = convB_ff[CMPC_B_MUXEN] && !convA_ff[CMPC_B_CONVEN];
  wire [2:0] nxt_negCh = nxt_negSel ? chSel_ff[2:0] : 3'h0;

  wire nxt_irq = nxt_flag && ctrl_ff[CMPC_B_IRQEN] && glob_ff[CMPC_B_GLOBIE];
  wire nxt_capSel = ctrl_ff[CMPC_B_CAPRT];
  wire nxt_capIn = ctrl_ff[CMPC_B_CAPRT] ? cmpSync : 1'b0;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] ctrlRd = {ctrl_ff[7:6], cmpSync, flag_ff, ctrl_ff[3:0]};
  wire [7:0] disRd = {6'h00, dis_ff};
  // Unmapped addresses read zero, so probing is harmless
  wire [7:0] rdByte = hitCtrl ? ctrlRd :
                      hitConvB ? convB_ff :
                      hitConvA ? convA_ff :
                      hitChSel ? chSel_ff :
                      hitDis ? disRd :
                      hitGlob ? glob_ff :
                      hitMask ? iMask_ff : CMPC_RST8;
  wire [31:0] nxt_rdat = {24'h000000, rdByte};

  // Single ack per request, one idle cycle after
  always_comb begin
    unique case (bus_ff)
      CMPC_BUS_IDLE: nxt_bus = busReq ? CMPC_BUS_ACK : CMPC_BUS_IDLE;
      CMPC_BUS_ACK: nxt_bus = CMPC_BUS_IDLE;
      default: nxt_bus = CMPC_BUS_IDLE;
    endcase
  end

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  // Idle-ack walk; keeps a held request from being retaken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_ff <= CMPC_BUS_IDLE;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // Ack is a one-cycle pulse after the taking edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= busReq;
    end
  end

  // Read data stands only in the ack cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdat_ff <= 32'h00000000;
    end else begin
      rdat_ff <= busReq ? nxt_rdat : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // power-off bit writable any time
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= CMPC_RST8;
    end else if (wrCtrl) begin
      ctrl_ff <= wbyte & CMPC_CTRL_WMASK;
    end
  end

  // Mux enable is the only live bit besides plain trigger storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      convB_ff <= CMPC_RST8;
    end else if (wrEn && hitConvB) begin
      convB_ff <= wbyte & CMPC_CONVB_MASK;
    end
  end

  // Converter enable overrides the mux; other bits are plain storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      convA_ff <= CMPC_RST8;
    end else if (wrEn && hitConvA) begin
      convA_ff <= wbyte;
    end
  end

  // Only the low three bits steer the comparator
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chSel_ff <= CMPC_RST8;
    end else if (wrEn && hitChSel) begin
      chSel_ff <= wbyte & CMPC_CHSEL_MASK;
    end
  end

  // Global enable stands in for processor core state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      glob_ff <= CMPC_RST8;
    end else if (wrEn && hitGlob) begin
      glob_ff <= wbyte;
    end
  end

  // Capture mask is storage only; the timer owns its effect
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      iMask_ff <= CMPC_RST8;
    end else if (wrEn && hitMask) begin
      iMask_ff <= wbyte;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dis_ff <= 2'h0;
    end else if (wrEn && hitDis) begin
      dis_ff <= wbyte[1:0];
    end
  end

  // ----------------------------------------
  // Event and output flops
  // ----------------------------------------
  // Edge history; vector ack is edge-detected so a held pulse clears once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 1'b0;
      ackVec_ff <= 1'b0;
    end else begin
      prev_ff <= cmpSync;
      ackVec_ff <= irqVectorAck;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // capture route flops; adds one cycle to the timer path
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      capIn_ff <= 1'b0;
      capSel_ff <= 1'b0;
    end else begin
      capIn_ff <= nxt_capIn;
      capSel_ff <= nxt_capSel;
    end
  end

  // Negative select registered so the mux pins never glitch on a write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      negSel_ff <= 1'b0;
      negCh_ff <= 3'h0;
    end else begin
      negSel_ff <= nxt_negSel;
      negCh_ff <= nxt_negCh;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // positive input select
  assign posSelBandgap = ctrl_ff[CMPC_B_BGSEL];
  assign cmpPowerOff = ctrl_ff[CMPC_B_PWROFF];
  assign negSelChannel = negSel_ff;
  assign negChannel = negCh_ff;
  assign irqReq = irq_ff;
  assign captureIn = capIn_ff;
  assign captureSelCmp = capSel_ff;
  assign negPinBufferOff = dis_ff[CMPC_B_NEGOFF];
  assign posPinBufferOff = dis_ff[CMPC_B_POSOFF];
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule : cmpc_top
`default_nettype wire

//--- tb/cmpc_analog_model.sv
`default_nettype none
module cmpc_analog_model (
  input wire logic cmpPowerOff,
  input wire logic posSelBandgap,
  input wire logic negSelChannel,
  input wire logic [2:0] negChannel,
  input wire logic [7:0] posLevel,
  input wire logic [7:0] negLevel,
  input wire logic [7:0] bandgapLevel,
  output logic cmpRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] plusIn;
  logic [7:0] minusIn;
  assign plusIn = posSelBandgap ? bandgapLevel : posLevel;
  // negative source; channel k sits at 32k+16
  assign minusIn = negSelChannel ? {negChannel, 5'h10} : negLevel;
  assign cmpRaw = !cmpPowerOff && (plusIn > minusIn);
endmodule : cmpc_analog_model
`default_nettype wire

//--- tb/cmpc_checker.sv
`default_nettype none
module cmpc_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_ack_o,
  input wire logic cmpRaw,
  input wire logic cmpPowerOff,
  input wire logic negSelChannel,
  input wire logic [2:0] negChannel,
  input wire logic irqVectorAck,
  input wire logic irqReq,
  input wire logic captureIn,
  input wire logic captureSelCmp,
  input wire logic negPinBufferOff,
  input wire logic posPinBufferOff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmpPrev_ff;
  logic [2:0] quiet_ff;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ----------------
  // Quiet time
  // ----------------
  // Edges since comparator moved; events need three to land
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmpPrev_ff <= 1'b0;
      quiet_ff <= 3'h0;
    end else begin
      cmpPrev_ff <= cmpRaw;
      quiet_ff <= (cmpRaw != cmpPrev_ff) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
    end
  end
  property p_mux;
    $changed({negSelChannel, negChannel}) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
  a_mux: assert property (p_mux) else $error("mux moved without write");
  property p_pin;
    !negSelChannel |-> negChannel == 3'h0; endproperty
  a_pin: assert property (p_pin) else $error("channel code with pin");
  property p_pwr;
    $changed(cmpPowerOff) |-> wb_ack_o || $past(wb_ack_o); endproperty
  a_pwr: assert property (p_pwr) else $error("power moved without write");
  property p_buf;
    $changed({negPinBufferOff, posPinBufferOff}) |-> wb_ack_o || $past(wb_ack_o); endproperty
  a_buf: assert property (p_buf) else $error("buffer bit moved without write");
  property p_cap;
    captureSelCmp && $past(captureSelCmp) |-> captureIn == $past(cmpRaw, 3); endproperty
  a_cap: assert property (p_cap) else $error("capture path latency");
  property p_noCap;
    !captureSelCmp && !$past(captureSelCmp) |-> !captureIn; endproperty
  a_noCap: assert property (p_noCap) else $error("capture path while off");
  property p_irq;
    $rose(irqReq) |-> quiet_ff <= 3'h5 || wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
  a_irq: assert property (p_irq) else $error("request without cause");
  property p_vec;
    $rose(irqVectorAck) && quiet_ff >= 3'h5 |-> ##3 !irqReq; endproperty
  a_vec: assert property (p_vec) else $error("vector left request");
endmodule : cmpc_checker
bind cmpc_top cmpc_checker u_chk (.clk_sys, .resetn, .wb_ack_o, .cmpRaw, .cmpPowerOff, .negSelChannel,
  .negChannel, .irqVectorAck, .irqReq, .captureIn, .captureSelCmp, .negPinBufferOff, .posPinBufferOff);
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb
  import cmpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, irqVectorAck = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, posLevel = 8'h00, negLevel = 8'h80, bandgapLevel = 8'hff;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdData;
  logic wb_ack_o, cmpRaw, cmpPowerOff, posSelBandgap, negSelChannel, irqReq, captureIn, captureSelCmp;
  logic negPinBufferOff, posPinBufferOff;
  logic [2:0] negChannel;
  int errCount = 0;
  int checksDone = 0;
  always #2.5 clk_sys = ~clk_sys;
  cmpc_top dut (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .cmpRaw, .cmpPowerOff, .posSelBandgap, .negSelChannel, .negChannel, .irqVectorAck, .irqReq,
    .captureIn, .captureSelCmp, .negPinBufferOff, .posPinBufferOff);
  cmpc_analog_model core (.cmpPowerOff, .posSelBandgap, .negSelChannel, .negChannel, .posLevel, .negLevel,
    .bandgapLevel, .cmpRaw);
  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : testDone
  // Classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdData = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50) begin
      errCount++;
      testDone();
    end
  endtask : bus
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    bus(adr, 1'b0, 8'h00);
    chk(rdData, {24'h0, exp});
  endtask : rd
  // Covers sync plus flag plus request latency
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask : settle
  // ----------------
  // Scenarios
  // ----------------
  task automatic tRegs();
    rd(CMPC_ADDR_CTRL, 8'h00);
    bus(CMPC_ADDR_DIDIS, 1'b1, 8'hff);
    rd(CMPC_ADDR_DIDIS, 8'h03);
    chk({30'h0, negPinBufferOff, posPinBufferOff}, 32'h3);
    bus(CMPC_ADDR_DIDIS, 1'b1, 8'h01);
    chk({30'h0, negPinBufferOff, posPinBufferOff}, 32'h1);
    bus(8'h40, 1'b1, 8'hff);
    rd(8'h40, 8'h00);
    $display("registers done");
  endtask : tRegs
  task automatic tMux();
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h11);
    bus(CMPC_ADDR_CONVB, 1'b1, 8'h40);
    posLevel <= 8'h50;
    negLevel <= 8'h20;
    for (int k = 0; k < 8; k++) begin
      bus(CMPC_ADDR_CHSEL, 1'b1, k[7:0]);
      settle();
      chk({28'h0, negSelChannel, negChannel}, {28'h0, 1'b1, k[2:0]});
      rd(CMPC_ADDR_CTRL, {2'b00, k < 2, 5'h01});
    end
    bus(CMPC_ADDR_CONVA, 1'b1, 8'h80);
    settle();
    chk({28'h0, negSelChannel, negChannel}, 32'h0);
    rd(CMPC_ADDR_CTRL, 8'h21);
    bus(CMPC_ADDR_CONVB, 1'b1, 8'h00);
    bus(CMPC_ADDR_CONVA, 1'b1, 8'h00);
    settle();
    chk({28'h0, negSelChannel, negChannel}, 32'h0);
    $display("mux done");
  endtask : tMux
  task automatic tBandgap();
    posLevel <= 8'h00;
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h41);
    settle();
    chk({31'h0, posSelBandgap}, 32'h1);
    rd(CMPC_ADDR_CTRL, 8'h61);
    bus(CMPC_ADDR_CTRL, 1'b1, 8'hc1);
    chk({31'h0, cmpPowerOff}, 32'h1);
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h01);
    settle();
    $display("bandgap done");
  endtask : tBandgap
  // Modes walked with the interrupt disabled, toggle last
  task automatic tEvents();
    for (int m = 3; m >= 0; m--) begin
      bus(CMPC_ADDR_CTRL, 1'b1, {6'h04, m[1:0]});
      posLevel <= 8'hff;
      settle();
      rd(CMPC_ADDR_CTRL, {2'b00, 1'b1, m == 0 || m == 3, 2'b00, m[1:0]});
      bus(CMPC_ADDR_CTRL, 1'b1, {6'h04, m[1:0]});
      posLevel <= 8'h00;
      settle();
      rd(CMPC_ADDR_CTRL, {3'b000, m == 0 || m == 2, 2'b00, m[1:0]});
    end
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h08);
    rd(CMPC_ADDR_CTRL, 8'h18);
    chk({31'h0, irqReq}, 32'h0);
    bus(CMPC_ADDR_GLOB, 1'b1, 8'h80);
    settle();
    chk({31'h0, irqReq}, 32'h1);
    irqVectorAck <= 1'b1;
    @(posedge clk_sys);
    irqVectorAck <= 1'b0;
    settle();
    chk({31'h0, irqReq}, 32'h0);
    rd(CMPC_ADDR_CTRL, 8'h08);
    $display("events done");
  endtask : tEvents
  task automatic tCapture();
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h00);
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h05);
    posLevel <= 8'hff;
    settle();
    chk({30'h0, captureSelCmp, captureIn}, 32'h3);
    bus(CMPC_ADDR_CTRL, 1'b1, 8'h01);
    settle();
    chk({30'h0, captureSelCmp, captureIn}, 32'h0);
    $display("capture done");
  endtask : tCapture
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    tRegs();
    tMux();
    tBandgap();
    tEvents();
    tCapture();
    testDone();
  end
endmodule : tb
`default_nettype wire
